//--- inc/fio_cfg.svh
// Purpose: Constants for the fieldbus I/O mode and image-table block
// Assumes: 125 MHz clock
`ifndef FIO_CFG_SVH
`define FIO_CFG_SVH
`define FIO_OUT_TIMEOUT_US   1000
`define FIO_CLK_MHZ          125
`define FIO_OUT_TIMEOUT_CYC  (`FIO_OUT_TIMEOUT_US * `FIO_CLK_MHZ)
`define FIO_TX_PERIOD_CYC    16'h0400
`define FIO_VALID_RST        1'b1
`endif

//--- inc/fio_pkg.sv
// Purpose: Types for the fieldbus I/O mode and image-table block
// Assumes: Nothing
// Notes:   Mode codes are binary
package fio_pkg;
	typedef enum logic [1:0] {
		FIO_IDLE    = 2'b00,
		FIO_READY   = 2'b01,
		FIO_RUN_LK  = 2'b10,
		FIO_RUN_UL  = 2'b11
	} fio_mode_t;
	typedef enum logic [1:0] {
		FIO_PH_IN   = 2'b00,
		FIO_PH_OUT  = 2'b01
	} fio_phase_t;
endpackage : fio_pkg

//--- rtl/fio_core.sv
// Purpose: Mode sequencing and discrete I/O image tables
// Assumes: Inputs other than module pins are synchronous to clock
// Notes:   Pins from modules pass two flip-flops
`timescale 1ns/1ps
`include "fio_cfg.svh"
module fio_core
	import fio_pkg::*;
#(
	parameter int MODS        = 8,
	parameter int PTS         = 8,
	parameter int TIMEOUT_CYC = `FIO_OUT_TIMEOUT_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 clk_en,
	// Network side
	input  wire logic                 net_present,
	input  wire logic                 net_comm_ok,
	input  wire logic                 net_cfg_valid,
	input  wire logic                 net_cfg_enable,
	input  wire logic                 net_cmd_idle,
	input  wire logic                 net_cmd_run,
	input  wire logic                 net_cmd_unlock,
	input  wire logic                 net_cmd_ready,
	input  wire logic                 net_out_strobe,
	input  wire logic [MODS*PTS-1:0]  net_out_data,
	input  wire logic [MODS*PTS-1:0]  net_out_valid_n,
	input  wire logic                 net_out_fresh,
	input  wire logic                 net_force_req,
	input  wire logic                 net_force_in,
	input  wire logic [MODS*PTS-1:0]  net_force_mask,
	input  wire logic [MODS*PTS-1:0]  net_force_val,
	input  wire logic                 net_in_req,
	// Handheld programmer side
	input  wire logic                 prog_cfg_req,
	input  wire logic                 prog_force_req,
	input  wire logic                 prog_force_in,
	input  wire logic [MODS*PTS-1:0]  prog_force_mask,
	input  wire logic [MODS*PTS-1:0]  prog_force_val,
	// Configuration
	input  wire logic [MODS-1:0]      cfg_in_hold,
	input  wire logic [MODS*PTS-1:0]  cfg_out_hold,
	input  wire logic [MODS*PTS-1:0]  cfg_out_dflt,
	// I/O nest
	input  wire logic [MODS*PTS-1:0]  mod_in_pins,
	input  wire logic [MODS-1:0]      mod_fault_pins,
	output logic [MODS*PTS-1:0]       mod_out,
	// Results
	output logic [1:0]                mode,
	output logic                      prog_cfg_ack,
	output logic                      prog_cfg_nak,
	output logic                      force_nak,
	output logic [MODS*PTS-1:0]       discrete_inputs,
	output logic [MODS*PTS-1:0]       discrete_input_validators,
	output logic [MODS*PTS-1:0]       discrete_output_validators,
	output logic [MODS*PTS-1:0]       out_processed,
	output logic                      commvar_valid,
	output logic [PTS-1:0]            commvar_data,
	output logic [PTS-1:0]            commvar_valid_n,
	output logic [7:0]                commvar_index
);
	localparam int N = MODS * PTS;

	initial begin
		if (MODS < 1 || MODS > 255 || PTS < 1 || TIMEOUT_CYC < 1)
			$error("fio_core: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [N-1:0]    in_s1_q, in_s2_q;
	logic [MODS-1:0] flt_s1_q, flt_s2_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_s1_q  <= '0;
			in_s2_q  <= '0;
			flt_s1_q <= '0;
			flt_s2_q <= '0;
		end else if (clk_en) begin
			in_s1_q  <= mod_in_pins;
			in_s2_q  <= in_s1_q;
			flt_s1_q <= mod_fault_pins;
			flt_s2_q <= flt_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencing
	// ----------------------------------------------------------------
	fio_mode_t mode_q, mode_d;
	wire in_run = (mode_q == FIO_RUN_LK) || (mode_q == FIO_RUN_UL);
	wire cfg_ok = net_cfg_valid && net_cfg_enable;
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			FIO_IDLE: begin
				if (net_present && net_comm_ok && cfg_ok)
					mode_d = FIO_READY;
			end
			FIO_READY: begin
				if (net_cmd_idle || !net_present)
					mode_d = FIO_IDLE;
				else if (net_cmd_run && net_comm_ok)
					mode_d = net_cmd_unlock ? FIO_RUN_UL : FIO_RUN_LK;
			end
			FIO_RUN_LK, FIO_RUN_UL: begin
				if (net_cmd_ready || !net_comm_ok || !net_present)
					mode_d = FIO_READY;
				else if (net_cmd_run)
					mode_d = net_cmd_unlock ? FIO_RUN_UL : FIO_RUN_LK;
			end
		endcase
	end
	wire enter_idle = (mode_q != FIO_IDLE) && (mode_d == FIO_IDLE);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			mode_q <= FIO_IDLE;
		else if (clk_en)
			mode_q <= mode_d;
	end

	// ----------------------------------------------------------------
	// Request gating
	// ----------------------------------------------------------------
	wire idle_rdy   = (mode_q == FIO_IDLE) || (mode_q == FIO_READY);
	wire prog_cfg_ok = (mode_q == FIO_IDLE);
	wire prog_frc_ok = prog_force_req && idle_rdy && !prog_cfg_req;
	wire net_frc_ok = net_force_req && (mode_q == FIO_READY);
	wire frc_ok     = prog_frc_ok || net_frc_ok;
	wire frc_bad    = (prog_force_req && !idle_rdy) ||
	                  (net_force_req && (mode_q != FIO_READY));
	wire frc_in     = prog_frc_ok ? prog_force_in : net_force_in;
	wire [N-1:0] frc_mask = prog_frc_ok ? prog_force_mask : net_force_mask;
	wire [N-1:0] frc_val  = prog_frc_ok ? prog_force_val : net_force_val;

	// ----------------------------------------------------------------
	// Force tables, kept apart from state and validator tables
	// ----------------------------------------------------------------
	logic [N-1:0] in_frc_flag_q, in_frc_val_q;
	logic [N-1:0] out_frc_flag_q, out_frc_val_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_frc_flag_q  <= '0;
			in_frc_val_q   <= '0;
			out_frc_flag_q <= '0;
			out_frc_val_q  <= '0;
		end else if (clk_en && frc_ok && frc_in) begin
			in_frc_flag_q <= frc_mask;
			in_frc_val_q  <= frc_val & frc_mask;
		end else if (clk_en && frc_ok) begin
			out_frc_flag_q <= frc_mask;
			out_frc_val_q  <= frc_val & frc_mask;
		end
	end

	// ----------------------------------------------------------------
	// Scan phase: input scan then output scan
	// ----------------------------------------------------------------
	fio_phase_t ph_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ph_q <= FIO_PH_IN;
		else if (clk_en)
			ph_q <= (ph_q == FIO_PH_IN) ? FIO_PH_OUT : FIO_PH_IN;
	end
	wire in_scan  = (ph_q == FIO_PH_IN);
	wire out_scan = (ph_q == FIO_PH_OUT);

	// ----------------------------------------------------------------
	// Discrete input table
	// ----------------------------------------------------------------
	logic [N-1:0] in_q, in_val_n_q;
	logic [N-1:0] in_scan_d, in_vscan_d;
	genvar g;
	generate
		for (g = 0; g < MODS; g++) begin : g_in
			wire [PTS-1:0] raw = in_s2_q[g*PTS +: PTS];
			wire [PTS-1:0] old = in_q[g*PTS +: PTS];
			wire [PTS-1:0] dfl = cfg_in_hold[g] ? old : '0;
			assign in_scan_d[g*PTS +: PTS]  = flt_s2_q[g] ? dfl : raw;
			assign in_vscan_d[g*PTS +: PTS] = {PTS{flt_s2_q[g]}};
		end
	endgenerate
	wire [N-1:0] in_d = (in_scan_d & ~in_frc_flag_q) |
	                    (in_frc_val_q & in_frc_flag_q);
	wire [N-1:0] iv_scan = (mode_q == FIO_IDLE) ? {N{1'b1}} : in_vscan_d;
	wire [N-1:0] iv_d    = iv_scan & ~in_frc_flag_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_q       <= '0;
			in_val_n_q <= {N{`FIO_VALID_RST}};
		end else if (clk_en && enter_idle) begin
			in_val_n_q <= {N{1'b1}};
		end else if (clk_en && in_scan) begin
			in_q       <= in_d;
			in_val_n_q <= iv_d;
		end
	end

	// ----------------------------------------------------------------
	// Discrete output table and validators
	// ----------------------------------------------------------------
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	logic [TW-1:0] to_cnt_q;
	logic          to_q;
	wire check_fresh = (mode_q == FIO_RUN_LK);
	wire rx_ok = net_out_strobe && in_run &&
	             (!check_fresh || net_out_fresh);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			to_cnt_q <= '0;
			to_q     <= 1'b1;
		end else if (clk_en) begin
			if (rx_ok || !in_run) begin
				to_cnt_q <= '0;
				to_q     <= !in_run;
			end else if (to_cnt_q == TW'(TIMEOUT_CYC - 1)) begin
				to_q     <= 1'b1;
			end else begin
				to_cnt_q <= to_cnt_q + 1'b1;
			end
		end
	end

	logic [N-1:0] q_rx_q, q_val_n_q, q_proc_q, q_out_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q_rx_q    <= '0;
			q_val_n_q <= {N{`FIO_VALID_RST}};
		end else if (clk_en && enter_idle) begin
			q_val_n_q <= {N{1'b1}};
		end else if (clk_en && rx_ok) begin
			q_rx_q    <= net_out_data;
			q_val_n_q <= net_out_valid_n;
		end else if (clk_en && (to_q || !in_run)) begin
			q_val_n_q <= {N{1'b1}};
		end
	end

	wire [N-1:0] q_dflt = (cfg_out_hold & q_proc_q) |
	                      (~cfg_out_hold & cfg_out_dflt);
	wire [N-1:0] q_proc_d = (q_rx_q & ~q_val_n_q) |
	                        (q_dflt & q_val_n_q);
	wire [N-1:0] q_out_d  = (q_proc_q & ~out_frc_flag_q) |
	                        (out_frc_val_q & out_frc_flag_q);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q_proc_q <= '0;
			q_out_q  <= '0;
		end else if (clk_en && out_scan) begin
			q_proc_q <= q_proc_d;
			q_out_q  <= q_out_d;
		end
	end

	// ----------------------------------------------------------------
	// Periodic input variables towards the network
	// ----------------------------------------------------------------
	logic [15:0] tx_cnt_q;
	logic [7:0]  tx_idx_q;
	logic        cv_valid_q;
	logic [PTS-1:0] cv_data_q, cv_vn_q;
	wire tx_tick = (tx_cnt_q == `FIO_TX_PERIOD_CYC) || net_in_req;
	wire tx_go   = tx_tick && in_run;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_cnt_q   <= '0;
			tx_idx_q   <= '0;
			cv_valid_q <= 1'b0;
			cv_data_q  <= '0;
			cv_vn_q    <= '0;
		end else if (clk_en) begin
			tx_cnt_q   <= tx_tick ? 16'h0000 : tx_cnt_q + 16'h0001;
			cv_valid_q <= tx_go;
			if (tx_go) begin
				cv_data_q <= in_q[tx_idx_q*PTS +: PTS];
				cv_vn_q   <= in_val_n_q[tx_idx_q*PTS +: PTS];
				tx_idx_q  <= (tx_idx_q == 8'(MODS - 1)) ? 8'h00
				             : tx_idx_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Programmer answers and force refusals
	// ----------------------------------------------------------------
	logic ack_q, nak_q, fnak_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_q  <= 1'b0;
			nak_q  <= 1'b0;
			fnak_q <= 1'b0;
		end else if (clk_en) begin
			ack_q  <= prog_cfg_req && prog_cfg_ok;
			nak_q  <= prog_cfg_req && !prog_cfg_ok;
			fnak_q <= frc_bad;
		end
	end

	assign mod_out                    = q_out_q;
	assign mode                       = mode_q;
	assign prog_cfg_ack               = ack_q;
	assign prog_cfg_nak               = nak_q;
	assign force_nak                  = fnak_q;
	assign discrete_inputs            = in_q;
	assign discrete_input_validators  = in_val_n_q;
	assign discrete_output_validators = q_val_n_q;
	assign out_processed              = q_proc_q;
	assign commvar_valid              = cv_valid_q;
	assign commvar_data               = cv_data_q;
	assign commvar_valid_n            = cv_vn_q;
	assign commvar_index              = tx_idx_q;
endmodule : fio_core

//--- verification/fieldbus_io_mode_and_image_tables_tb_top.sv
// Purpose: Self-checking bench for the fieldbus I/O mode block
// Assumes: Two modules of four points, short output timeout
// Notes:   Expected tables are kept in the bench
`timescale 1ns/1ps
module fieldbus_io_mode_and_image_tables_tb_top;
	import fio_pkg::*;
	localparam int M = 2;
	localparam int P = 4;
	localparam int N = 8;
	localparam int TO = 20;
	logic clock, reset_n, clk_en, net_present, net_comm_ok, net_cfg_valid;
	logic net_cfg_enable, net_cmd_idle, net_cmd_run, net_cmd_unlock;
	logic net_cmd_ready, net_out_strobe, net_out_fresh, net_force_req;
	logic net_force_in, net_in_req, prog_cfg_req, prog_force_req;
	logic prog_force_in, prog_cfg_ack, prog_cfg_nak, force_nak;
	logic mdl_go, mdl_slow, mdl_stale;
	logic commvar_valid;
	logic [1:0] mode;
	logic [M-1:0] cfg_in_hold, mod_fault_pins;
	logic [P-1:0] commvar_data, commvar_valid_n;
	logic [7:0] commvar_index;
	logic [N-1:0] net_out_data, net_out_valid_n, net_force_mask, net_force_val;
	logic [N-1:0] prog_force_mask, prog_force_val, cfg_out_hold, cfg_out_dflt;
	logic [N-1:0] mod_in_pins, mod_out, discrete_inputs, mdl_bad, exp_in;
	logic [N-1:0] discrete_input_validators, discrete_output_validators;
	logic [N-1:0] out_processed, p_d, p_v, e_out;
	int fails, tests_run, k, m;
	fio_core #(.MODS(M), .PTS(P), .TIMEOUT_CYC(TO)) u_fio_core (.clock,
		.reset_n, .clk_en, .net_present, .net_comm_ok, .net_cfg_valid,
		.net_cfg_enable, .net_cmd_idle, .net_cmd_run, .net_cmd_unlock,
		.net_cmd_ready, .net_out_strobe, .net_out_data, .net_out_valid_n,
		.net_out_fresh, .net_force_req, .net_force_in, .net_force_mask,
		.net_force_val, .net_in_req, .prog_cfg_req, .prog_force_req,
		.prog_force_in, .prog_force_mask, .prog_force_val, .cfg_in_hold,
		.cfg_out_hold, .cfg_out_dflt, .mod_in_pins, .mod_fault_pins, .mod_out,
		.mode, .prog_cfg_ack, .prog_cfg_nak, .force_nak, .discrete_inputs,
		.discrete_input_validators, .discrete_output_validators,
		.out_processed, .commvar_valid, .commvar_data, .commvar_valid_n,
		.commvar_index);
	fio_net_model #(.N(N)) u_fio_net_model (.clock, .go(mdl_go),
		.slow(mdl_slow), .stale(mdl_stale), .bad(mdl_bad),
		.strobe(net_out_strobe), .data(net_out_data),
		.valid_n(net_out_valid_n), .fresh(net_out_fresh));
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task automatic frc(input logic net, input logic inp,
		input logic [N-1:0] fm, input logic [N-1:0] fv);
		{net_force_in, prog_force_in} = {inp, inp};
		{net_force_mask, prog_force_mask} = {fm, fm};
		{net_force_val, prog_force_val} = {fv, fv};
		if (net)
			pulse(net_force_req);
		else
			pulse(prog_force_req);
	endtask : frc
	task automatic sync_out(input logic acc);
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (!net_out_strobe && k < 40);
		if (k >= 40) begin
			fails++;
			test_done();
		end
		if (acc)
			{p_d, p_v} = {net_out_data, net_out_valid_n};
		cyc(4);
		e_out = (p_d & ~p_v) | (cfg_out_dflt & p_v);
	endtask : sync_out
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		void'($urandom(27039));
		{net_present, net_comm_ok, net_cfg_valid, net_cfg_enable, net_cmd_idle,
			net_cmd_run, net_cmd_unlock, net_cmd_ready, net_force_req,
			net_in_req, prog_cfg_req, prog_force_req, mdl_go, mdl_slow,
			mdl_stale, reset_n, cfg_in_hold, mod_fault_pins} = '0;
		{net_force_in, prog_force_in, clk_en} = 3'h1;
		{net_force_mask, net_force_val, prog_force_mask, prog_force_val} = '0;
		{cfg_out_hold, mdl_bad, p_d, fails, tests_run} = '0;
		{cfg_out_dflt, p_v, mod_in_pins} = {8'hA5, 8'hFF, N'($urandom)};
		cyc(6);
		reset_n = 1'b1;
		cyc(1);
		chk({6'h0, mode}, 8'h00);
		chk(discrete_input_validators, 8'hFF);
		pulse(net_force_req);
		chk({7'h0, force_nak}, 8'h01);
		frc(0, 1, 8'h81, 8'h01);
		cyc(3);
		exp_in = (mod_in_pins & 8'h7E) | 8'h01;
		chk(discrete_inputs, exp_in);
		chk(discrete_input_validators, 8'h7E);
		{net_present, net_comm_ok, net_cfg_valid} = 3'h7;
		cyc(2);
		chk({6'h0, mode}, 8'h00);
		net_cfg_enable = 1'b1;
		cyc(1);
		chk({6'h0, mode}, 8'h01);
		pulse(prog_cfg_req);
		chk({7'h0, prog_cfg_nak}, 8'h01);
		frc(0, 1, 8'h00, 8'h00);
		mod_in_pins = N'($urandom);
		cyc(5);
		exp_in = mod_in_pins;
		chk(discrete_inputs, exp_in);
		chk(discrete_input_validators, 8'h00);
		frc(1, 1, 8'h10, ~exp_in & 8'h10);
		chk({7'h0, force_nak}, 8'h00);
		cyc(3);
		chk(discrete_inputs, exp_in ^ 8'h10);
		frc(1, 1, 8'h00, 8'h00);
		mod_fault_pins = 2'h2;
		cyc(6);
		chk(discrete_inputs, exp_in & 8'h0F);
		chk(discrete_input_validators, 8'hF0);
		{cfg_in_hold, mod_fault_pins, mod_in_pins} = {4'h5, ~exp_in};
		cyc(6);
		chk(discrete_inputs, {~exp_in[7:4], exp_in[3:0]});
		chk(discrete_input_validators, 8'h0F);
		mod_fault_pins = 2'h0;
		frc(0, 0, 8'h0F, 8'h05);
		cyc(3);
		chk(mod_out, 8'hA0 | 8'h05);
		cfg_out_dflt = 8'h3C;
		cyc(4);
		chk(out_processed, 8'h3C);
		frc(0, 0, 8'h00, 8'h00);
		cyc(3);
		chk(mod_out, 8'h3C);
		{mdl_go, net_cmd_run, exp_in} = {2'h3, mod_in_pins};
		cyc(1);
		net_cmd_run = 1'b0;
		chk({6'h0, mode}, 8'h02);
		pulse(prog_cfg_req);
		chk({7'h0, prog_cfg_nak}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			{mdl_bad, mdl_slow} = {N'($urandom), i[0]};
			sync_out(1);
			chk(out_processed, e_out);
			chk(mod_out, e_out);
			chk(discrete_output_validators, p_v);
		end
		mdl_stale = 1'b1;
		sync_out(0);
		chk(out_processed, e_out);
		pulse(net_cmd_ready);
		chk({6'h0, mode}, 8'h01);
		{net_cmd_run, net_cmd_unlock} = 2'h3;
		cyc(1);
		{net_cmd_run, net_cmd_unlock} = 2'h0;
		chk({6'h0, mode}, 8'h03);
		sync_out(1);
		chk(out_processed, e_out);
		m = int'(commvar_index[0]);
		pulse(net_in_req);
		for (k = 0; commvar_valid !== 1'b1 && k < 3; k++)
			cyc(1);
		chk({7'h0, commvar_valid}, 8'h01);
		chk({4'h0, commvar_data}, {4'h0, exp_in[m*P +: P]});
		chk({4'h0, commvar_valid_n}, 8'h00);
		mdl_go = 1'b0;
		cyc(TO + 8);
		chk(discrete_output_validators, 8'hFF);
		chk(out_processed, cfg_out_dflt);
		net_comm_ok = 1'b0;
		cyc(1);
		chk({6'h0, mode}, 8'h01);
		{net_comm_ok, net_cfg_enable} = 2'h2;
		pulse(net_cmd_idle);
		chk({6'h0, mode}, 8'h00);
		cyc(2);
		chk(discrete_input_validators, 8'hFF);
		pulse(prog_cfg_req);
		chk({7'h0, prog_cfg_ack}, 8'h01);
		chk({6'h0, mode}, 8'h00);
		test_done();
	end
endmodule : fieldbus_io_mode_and_image_tables_tb_top

//--- verification/fio_core_props.sv
// Purpose: Port assertions for fio_core
// Assumes: One clock domain
// Notes:   Bound to every fio_core instance
`timescale 1ns/1ps
module fio_core_props
	import fio_pkg::*;
#(
	parameter int MODS        = 8,
	parameter int PTS         = 8,
	parameter int TIMEOUT_CYC = 20
) (
	input wire logic                clock,
	input wire logic                reset_n,
	input wire logic                clk_en,
	input wire logic                net_present,
	input wire logic                net_comm_ok,
	input wire logic                net_cfg_valid,
	input wire logic                net_cfg_enable,
	input wire logic                net_cmd_run,
	input wire logic                net_out_strobe,
	input wire logic                net_force_req,
	input wire logic                net_in_req,
	input wire logic                prog_cfg_req,
	input wire logic                prog_force_req,
	input wire logic [MODS*PTS-1:0] cfg_out_hold,
	input wire logic [MODS*PTS-1:0] cfg_out_dflt,
	input wire logic [1:0]          mode,
	input wire logic                prog_cfg_nak,
	input wire logic                force_nak,
	input wire logic [MODS*PTS-1:0] discrete_output_validators,
	input wire logic [MODS*PTS-1:0] out_processed,
	input wire logic                commvar_valid
);
	// ----------------------------------------
	// Cycles in Run since the last output strobe
	// ----------------------------------------
	int unsigned idle_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			idle_q <= 0;
		else if (net_out_strobe || !mode[1])
			idle_q <= 0;
		else if (clk_en)
			idle_q <= idle_q + 1;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	sequence s_not_run;
		(!mode[1]) [*2];
	endsequence
	sequence s_dflt;
		(clk_en && &discrete_output_validators && cfg_out_hold == '0
			&& $stable(cfg_out_dflt)) [*4];
	endsequence
	a_cfg_gate: assert property (
		mode == 2'h0 && clk_en && !(net_cfg_valid && net_cfg_enable)
		|=> mode == 2'h0) else $error("idle left without configuration");
	a_ready_wait: assert property (
		mode == 2'h1 && !net_cmd_run |=> !mode[1])
		else $error("run entered without command");
	a_cfg_refuse: assert property (
		prog_cfg_req && clk_en && mode != 2'h0 |=> prog_cfg_nak)
		else $error("programmer change not refused");
	a_net_force: assert property (
		net_force_req && clk_en && mode != 2'h1 |=> force_nak)
		else $error("network force not refused");
	a_prog_force: assert property (
		prog_force_req && clk_en && mode[1] |=> force_nak)
		else $error("programmer force in run not refused");
	a_comm_loss: assert property (
		mode[1] && clk_en && !net_comm_ok |=> mode == 2'h1)
		else $error("run kept after link loss");
	a_no_net: assert property (
		mode == 2'h0 && !net_present |=> mode == 2'h0)
		else $error("idle left without network");
	a_reset_idle: assert property (
		$rose(reset_n) |-> mode == 2'h0) else $error("mode not idle");
	a_out_invalid: assert property (
		s_not_run |-> &discrete_output_validators)
		else $error("output validators valid outside run");
	a_out_timeout: assert property (
		idle_q > TIMEOUT_CYC + 3 |-> &discrete_output_validators)
		else $error("output timeout not flagged");
	a_out_default: assert property (
		s_dflt |-> out_processed == cfg_out_dflt)
		else $error("invalid output not defaulted");
	a_in_answer: assert property (
		net_in_req && clk_en && mode[1] |-> ##[1:3] commvar_valid)
		else $error("input request not answered");
endmodule : fio_core_props
bind fio_core fio_core_props #(.MODS(MODS), .PTS(PTS),
	.TIMEOUT_CYC(TIMEOUT_CYC)) u_fio_core_props (.clock, .reset_n, .clk_en,
	.net_present, .net_comm_ok, .net_cfg_valid, .net_cfg_enable, .net_cmd_run,
	.net_out_strobe, .net_force_req, .net_in_req, .prog_cfg_req,
	.prog_force_req, .cfg_out_hold, .cfg_out_dflt, .mode, .prog_cfg_nak,
	.force_nak, .discrete_output_validators, .out_processed,
	.commvar_valid);

//--- verification/fio_net_model.sv
// Purpose: Network controller sending output variables
// Assumes: Driven 1 ns after the rising edge
// Notes:   Data and validator lines toggle between strobes
`timescale 1ns/1ps
module fio_net_model #(
	parameter int N = 8
) (
	input wire logic         clock,
	input wire logic         go,
	input wire logic         slow,
	input wire logic         stale,
	input wire logic [N-1:0] bad,
	output logic             strobe,
	output logic [N-1:0]     data,
	output logic [N-1:0]     valid_n,
	output logic             fresh
);
	int gap;
	logic g, sl, st;
	logic [N-1:0] b;
	initial begin
		{strobe, data, valid_n, fresh, gap} = '0;
		forever begin
			@(posedge clock);
			{g, sl, st, b} = {go, slow, stale, bad};
			#1;
			strobe = 1'b0;
			data = ~data;
			valid_n = ~valid_n;
			gap = gap + 1;
			if (g && gap >= (sl ? 16 : 6)) begin
				gap = 0;
				strobe = 1'b1;
				data = N'($urandom);
				valid_n = b;
				fresh = !st;
			end
		end
	end
endmodule : fio_net_model
